//--- rtl/cancx_dev.sv
// Purpose: CAN controller register side: modes, filters, receive FIFO, transmit buffers
// Assumes: Host is on sys_clk_i; CAN frame ports are same-clock logic
// Notes:   Bit-level CAN framing lives outside; this end presents whole frames
//
// What this block does
// - Reset leaves mode register bit 0 set
// - Host writes 0Ch to clock source register
// - Clock source write needs A6h unlock first
// - Bit timing at 09h/0Ah set in reset
// - Eight masks from 50h; one bits ignore
// - Filters up to 4Fh demand exact match
// - Pair enables 70h/71h, interrupts 72h/73h
// - IE bit 0 enables receive interrupt
// - C8h enables transceiver, normal speed, no listen
// - Clearing mode bit 0 starts operation
// - Enabled receive event drives interrupt low
// - Head frame shown at 10h to 1Dh
// - Command bit 0 releases head frame
// - 7Ah counts frames; host drains to zero
// - Reading 74h and 75h clears them
// - Info b7 selects format; length 0 to 8
// - Out-of-range identifier sends no frame
// - Payload bytes at 86h to 8Dh
// - Request bit per buffer starts transmission
// - Lower identifier wins; loser retries later
`timescale 1ns/10ps
`include "cancx_map.svh"
module cancx_dev #(
  parameter int RX_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // Register port
  cancx_if.dev             bus,
  // Received frames from the CAN side
  input  wire logic        can_rx_valid_i,
  input  wire logic        can_rx_ext_i,
  input  wire logic [28:0] can_rx_id_i,
  input  wire logic [3:0]  can_rx_dlc_i,
  input  wire logic [63:0] can_rx_data_i,
  // Frame to send and its arbitration
  output logic             can_tx_valid_o,
  output logic      [7:0]  can_tx_info_o,
  output logic      [31:0] can_tx_id_o,
  output logic      [63:0] can_tx_data_o,
  input  wire logic        can_rival_valid_i,
  input  wire logic        can_rival_ext_i,
  input  wire logic [28:0] can_rival_id_i,
  input  wire logic        can_tx_done_i,
  // Configuration outputs
  output logic             xcvr_en_o,
  output logic             normal_speed_o,
  output logic             listen_only_o,
  output logic      [7:0]  clk_src_o,
  output logic      [15:0] bit_timing_o
);
  cancx_pkg::cancx_dev_t q, d;
  logic [7:0]   hit;
  logic [111:0] rx_word;
  logic [111:0] head;
  logic [7:0]   rx_cnt;
  logic         rx_full;
  logic         rx_accept;
  logic         rx_push;
  logic         rx_pop;
  logic         in_acc;
  logic         in_tx;
  logic [3:0]   tx_byte;

  // ==========================================================================
  // Helpers
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [2:0] lowest(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Lower key wins; standard IDs sit in the top 11 bits of the extended space
  function automatic logic [28:0] arb_key(input logic ext, input logic [28:0] id);
    return ext ? id : {id[10:0], 18'h0};
  endfunction

  // ==========================================================================
  // Acceptance: pair k uses filter k mod 4 and mask k
  for (genvar k = 0; k < 8; k++) begin : g_pair
    logic [31:0] filt;
    logic [31:0] msk;
    assign filt = {q.acc[(k%4)*4], q.acc[(k%4)*4+1], q.acc[(k%4)*4+2], q.acc[(k%4)*4+3]};
    assign msk  = {q.acc[16+k*4], q.acc[17+k*4], q.acc[18+k*4], q.acc[19+k*4]};
    assign hit[k] = q.fen[k] &&
                    ((({3'h0, can_rx_id_i} ^ filt) & ~msk) == 32'h0);
  end

  assign rx_accept = can_rx_valid_i && !q.mode[`CANCX_MODE_RSTB] && (|hit);
  assign rx_push   = rx_accept && !rx_full;
  assign rx_pop    = bus.reg_wr && (bus.reg_addr == `CANCX_A_CMD) && bus.reg_wdata[0];
  assign rx_word   = {can_rx_ext_i, 3'h0, can_rx_dlc_i, 3'h0, can_rx_id_i, can_rx_data_i,
                      5'h00, lowest(hit)};

  cancx_rxfifo #(
    .W     (112),
    .DEPTH (RX_DEPTH)
  ) u_rxfifo (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .push_i    (rx_push),
    .wdata_i   (rx_word),
    .pop_i     (rx_pop),
    .head_o    (head),
    .count_o   (rx_cnt),
    .full_o    (rx_full)
  );

  assign in_acc  = in_range(bus.reg_addr, `CANCX_A_FILT, `CANCX_A_ACCEND);
  assign tx_byte = 4'(bus.reg_addr[3:0] - 4'h1);
  assign in_tx   = bus.reg_addr[7] && (bus.reg_addr[3:0] != 4'h0) &&
                   (bus.reg_addr[3:0] <= `CANCX_A_TXLAST);

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    // Register writes
    if (bus.reg_wr) begin
      if (bus.reg_addr == `CANCX_A_MODE) d.mode = bus.reg_wdata;
      if (bus.reg_addr == `CANCX_A_IE) d.ie = bus.reg_wdata;
      if (bus.reg_addr == `CANCX_A_TXREQ) d.txreq = q.txreq | bus.reg_wdata;
      if (q.mode[`CANCX_MODE_RSTB]) begin
        if (bus.reg_addr == `CANCX_A_BT0) d.bt[0] = bus.reg_wdata;
        if (bus.reg_addr == `CANCX_A_BT1) d.bt[1] = bus.reg_wdata;
      end
      if (in_acc) d.acc[6'(bus.reg_addr - `CANCX_A_FILT)] = bus.reg_wdata;
      if (bus.reg_addr == `CANCX_A_FEN_L) d.fen[7:0] = bus.reg_wdata;
      if (bus.reg_addr == `CANCX_A_FEN_H) d.fen[15:8] = bus.reg_wdata;
      if (bus.reg_addr == `CANCX_A_FIE_L) d.fie[7:0] = bus.reg_wdata;
      if (bus.reg_addr == `CANCX_A_FIE_H) d.fie[15:8] = bus.reg_wdata;
      if (bus.reg_addr == `CANCX_A_LOCK) d.unlocked = (bus.reg_wdata == `CANCX_UNLOCK_KEY);
      if (bus.reg_addr == `CANCX_A_CLKSRC) begin
        if (q.unlocked) d.clksrc = bus.reg_wdata;
        d.unlocked = 1'b0;
      end
      if (in_tx) d.txb[bus.reg_addr[6:4]][tx_byte] = bus.reg_wdata;
    end
    // Register reads; status clears on read, a same-cycle event still lands below
    if (bus.reg_rd) begin
      d.rvalid = 1'b1;
      d.rdata  = 8'h00;
      if (bus.reg_addr == `CANCX_A_MODE) d.rdata = q.mode;
      if (bus.reg_addr == `CANCX_A_IE) d.rdata = q.ie;
      if (bus.reg_addr == `CANCX_A_TXREQ) d.rdata = q.txreq;
      if (bus.reg_addr == `CANCX_A_BT0) d.rdata = q.bt[0];
      if (bus.reg_addr == `CANCX_A_BT1) d.rdata = q.bt[1];
      if (in_range(bus.reg_addr, `CANCX_A_RXBUF, `CANCX_A_RXEND)) begin
        d.rdata = head[8'd111 - {bus.reg_addr[3:0], 3'h0} -: 8];
      end
      if (in_acc) d.rdata = q.acc[6'(bus.reg_addr - `CANCX_A_FILT)];
      if (bus.reg_addr == `CANCX_A_FEN_L) d.rdata = q.fen[7:0];
      if (bus.reg_addr == `CANCX_A_FEN_H) d.rdata = q.fen[15:8];
      if (bus.reg_addr == `CANCX_A_FIE_L) d.rdata = q.fie[7:0];
      if (bus.reg_addr == `CANCX_A_FIE_H) d.rdata = q.fie[15:8];
      if (bus.reg_addr == `CANCX_A_ST_L) begin
        d.rdata = q.st_l;
        d.st_l  = 8'h00;
      end
      if (bus.reg_addr == `CANCX_A_ST_H) begin
        d.rdata = q.st_h;
        d.st_h  = 8'h00;
      end
      if (bus.reg_addr == `CANCX_A_CLKSRC) d.rdata = q.clksrc;
      if (bus.reg_addr == `CANCX_A_RXCNT) d.rdata = rx_cnt;
      if (in_tx) d.rdata = q.txb[bus.reg_addr[6:4]][tx_byte];
    end
    // Receive events
    if (rx_accept) d.st_l = d.st_l | hit;
    if (rx_accept && rx_full) d.st_h[`CANCX_STH_OVR] = 1'b1;
    // Transmit sequencing
    case (q.tx_st)
      cancx_pkg::TX_IDLE: begin
        if (!q.mode[`CANCX_MODE_RSTB] && (|q.txreq)) begin
          d.tx_grp  = lowest(q.txreq);
          d.tx_info = q.txb[d.tx_grp][0];
          d.tx_id   = {q.txb[d.tx_grp][1], q.txb[d.tx_grp][2],
                       q.txb[d.tx_grp][3], q.txb[d.tx_grp][4]};
          d.tx_data = {q.txb[d.tx_grp][5], q.txb[d.tx_grp][6], q.txb[d.tx_grp][7],
                       q.txb[d.tx_grp][8], q.txb[d.tx_grp][9], q.txb[d.tx_grp][10],
                       q.txb[d.tx_grp][11], q.txb[d.tx_grp][12]};
          if ((d.tx_info[3:0] > `CANCX_DLC_MAX) ||
              (d.tx_id > (d.tx_info[`CANCX_FI_EXT] ? `CANCX_EXT_MAX : `CANCX_STD_MAX))) begin
            d.txreq[d.tx_grp]            = 1'b0;
            d.st_h[`CANCX_STH_TXREJ]     = 1'b1;
          end else begin
            d.tx_valid = 1'b1;
            d.tx_st    = cancx_pkg::TX_ARB;
          end
        end
      end
      cancx_pkg::TX_ARB: begin
        if (can_rival_valid_i && (arb_key(can_rival_ext_i, can_rival_id_i) <
            arb_key(q.tx_info[`CANCX_FI_EXT], q.tx_id[28:0]))) begin
          d.tx_valid               = 1'b0;
          d.st_h[`CANCX_STH_ARBL]  = 1'b1;
          d.tx_st                  = cancx_pkg::TX_IDLE;
        end else begin
          d.tx_st = cancx_pkg::TX_SEND;
        end
      end
      cancx_pkg::TX_SEND: begin
        if (can_tx_done_i) begin
          d.tx_valid               = 1'b0;
          d.txreq[q.tx_grp]        = 1'b0;
          d.st_h[`CANCX_STH_TXOK]  = 1'b1;
          d.tx_st                  = cancx_pkg::TX_IDLE;
        end
      end
      default: d.tx_st = cancx_pkg::TX_IDLE;
    endcase
    // Reset mode forces the transmitter back to idle
    if (d.mode[`CANCX_MODE_RSTB]) begin
      d.tx_valid = 1'b0;
      d.tx_st    = cancx_pkg::TX_IDLE;
    end
    d.irq_n = !(d.ie[0] && (|(d.st_l & d.fie[7:0])));
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q       <= '0;
      q.mode  <= `CANCX_MODE_RST;
      q.irq_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign bus.reg_rdata    = q.rdata;
  assign bus.reg_rvalid   = q.rvalid;
  assign bus.irq_n        = q.irq_n;
  assign can_tx_valid_o   = q.tx_valid;
  assign can_tx_info_o    = q.tx_info;
  assign can_tx_id_o      = q.tx_id;
  assign can_tx_data_o    = q.tx_data;
  assign xcvr_en_o        = q.mode[`CANCX_MODE_XCVR];
  assign normal_speed_o   = q.mode[`CANCX_MODE_NSPD];
  assign listen_only_o    = q.mode[`CANCX_MODE_LOM];
  assign clk_src_o        = q.clksrc;
  assign bit_timing_o     = {q.bt[1], q.bt[0]};
endmodule // cancx_dev

//--- rtl/cancx_host.sv
// Purpose: Register master that sets up the controller, drains received frames, sends buffer 0
// Assumes: Controller answers reads one cycle after the strobe
// Notes:   One outstanding read at a time
`timescale 1ns/10ps
`include "cancx_map.svh"
module cancx_host #(
  parameter logic [7:0] BT0 = 8'h40,
  parameter logic [7:0] BT1 = 8'h3a
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  // Register port
  cancx_if.host             bus,
  // User commands
  input  wire logic         init_start_i,
  input  wire logic         tx_start_i,
  input  wire logic [7:0]   tx_info_i,
  input  wire logic [31:0]  tx_id_i,
  input  wire logic [63:0]  tx_data_i,
  // User results
  output logic              init_done_o,
  output logic              busy_o,
  output logic      [7:0]   rx_byte_o,
  output logic      [3:0]   rx_idx_o,
  output logic              rx_valid_o,
  output logic              rx_last_o,
  output logic      [15:0]  status_o
);
  cancx_pkg::cancx_host_t q, d;

  // Setup sequence as {offset, value}
  function automatic logic [15:0] init_step(input logic [4:0] i);
    case (i)
      5'h00:   return {`CANCX_A_LOCK, `CANCX_UNLOCK_KEY};
      5'h01:   return {`CANCX_A_CLKSRC, `CANCX_CLK_XTAL};
      5'h02:   return {`CANCX_A_BT0, BT0};
      5'h03:   return {`CANCX_A_BT1, BT1};
      5'h04:   return {`CANCX_A_MASK, `CANCX_MASK_ALL};
      5'h05:   return {8'(`CANCX_A_MASK + 8'h01), `CANCX_MASK_ALL};
      5'h06:   return {8'(`CANCX_A_MASK + 8'h02), `CANCX_MASK_ALL};
      5'h07:   return {8'(`CANCX_A_MASK + 8'h03), `CANCX_MASK_ALL};
      5'h08:   return {`CANCX_A_FEN_L, 8'h01};
      5'h09:   return {`CANCX_A_FEN_H, 8'h00};
      5'h0a:   return {`CANCX_A_FIE_L, 8'h01};
      5'h0b:   return {`CANCX_A_FIE_H, 8'h00};
      5'h0c:   return {`CANCX_A_IE, 8'h01};
      default: return {`CANCX_A_MODE, `CANCX_MODE_RUN};
    endcase
  endfunction

  always_comb begin
    d = q;
    d.wr       = 1'b0;
    d.rd       = 1'b0;
    d.rx_valid = 1'b0;
    d.rx_last  = 1'b0;
    case (q.st)
      cancx_pkg::H_IDLE: begin
        d.idx = 5'h00;
        if (init_start_i) begin
          d.st = cancx_pkg::H_INIT;
        end else if (q.init_done && !bus.irq_n) begin
          d.st = cancx_pkg::H_RXRD;
        end else if (q.init_done && tx_start_i) begin
          d.txb = {tx_info_i, tx_id_i, tx_data_i};
          d.st  = cancx_pkg::H_TXLD;
        end
      end
      cancx_pkg::H_INIT: begin
        d.wr                = 1'b1;
        {d.addr, d.wdata}   = init_step(q.idx);
        d.idx               = 5'(q.idx + 5'h01);
        if (q.idx == 5'(`CANCX_INIT_STEPS - 5'h01)) begin
          d.init_done = 1'b1;
          d.st        = cancx_pkg::H_IDLE;
        end
      end
      cancx_pkg::H_RXRD: begin
        if (!q.waitr) begin
          d.rd    = 1'b1;
          d.waitr = 1'b1;
          d.addr  = 8'(`CANCX_A_RXBUF + {3'h0, q.idx});
        end else if (bus.reg_rvalid) begin
          d.waitr    = 1'b0;
          d.rx_byte  = bus.reg_rdata;
          d.rx_idx   = q.idx[3:0];
          d.rx_valid = 1'b1;
          d.idx      = 5'(q.idx + 5'h01);
          if (q.idx == 5'(`CANCX_RX_BYTES - 1)) begin
            d.rx_last = 1'b1;
            d.st      = cancx_pkg::H_REL;
          end
        end
      end
      cancx_pkg::H_REL: begin
        d.wr    = 1'b1;
        d.addr  = `CANCX_A_CMD;
        d.wdata = 8'h01;
        d.st    = cancx_pkg::H_CNT;
      end
      cancx_pkg::H_CNT: begin
        d.idx = 5'h00;
        if (!q.waitr) begin
          d.rd    = 1'b1;
          d.waitr = 1'b1;
          d.addr  = `CANCX_A_RXCNT;
        end else if (bus.reg_rvalid) begin
          d.waitr = 1'b0;
          d.st    = (bus.reg_rdata == 8'h00) ? cancx_pkg::H_STAT : cancx_pkg::H_RXRD;
        end
      end
      cancx_pkg::H_STAT: begin
        if (!q.waitr) begin
          d.rd    = 1'b1;
          d.waitr = 1'b1;
          d.addr  = q.idx[0] ? `CANCX_A_ST_H : `CANCX_A_ST_L;
        end else if (bus.reg_rvalid) begin
          d.waitr = 1'b0;
          d.idx   = 5'(q.idx + 5'h01);
          if (q.idx[0]) begin
            d.status[15:8] = bus.reg_rdata;
            d.st           = cancx_pkg::H_IDLE;
          end else begin
            d.status[7:0] = bus.reg_rdata;
          end
        end
      end
      cancx_pkg::H_TXLD: begin
        d.wr    = 1'b1;
        d.addr  = 8'(`CANCX_A_TXINFO + {3'h0, q.idx});
        d.wdata = q.txb[4'd12 - q.idx[3:0]];
        d.idx   = 5'(q.idx + 5'h01);
        if (q.idx == 5'h0c) d.st = cancx_pkg::H_TXGO;
      end
      cancx_pkg::H_TXGO: begin
        d.wr    = 1'b1;
        d.addr  = `CANCX_A_TXREQ;
        d.wdata = 8'h01;
        d.st    = cancx_pkg::H_IDLE;
      end
      default: d.st = cancx_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.reg_wr    = q.wr;
  assign bus.reg_rd    = q.rd;
  assign bus.reg_addr  = q.addr;
  assign bus.reg_wdata = q.wdata;
  assign init_done_o   = q.init_done;
  assign busy_o        = (q.st != cancx_pkg::H_IDLE);
  assign rx_byte_o     = q.rx_byte;
  assign rx_idx_o      = q.rx_idx;
  assign rx_valid_o    = q.rx_valid;
  assign rx_last_o     = q.rx_last;
  assign status_o      = q.status;
endmodule // cancx_host

//--- rtl/cancx_if.sv
// Purpose: Register port and interrupt line between host and CAN controller
// Assumes: Both ends on sys_clk_i
// Notes:   Read data answers one cycle after the read strobe
`timescale 1ns/10ps
interface cancx_if;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       irq_n;
  modport dev  (input reg_wr, reg_rd, reg_addr, reg_wdata,
                output reg_rdata, reg_rvalid, irq_n);
  modport host (output reg_wr, reg_rd, reg_addr, reg_wdata,
                input reg_rdata, reg_rvalid, irq_n);
endinterface // cancx_if

//--- rtl/cancx_map.svh
// Purpose: Register offsets, field positions, reset and key values of the CAN register port
// Assumes: Byte-wide register port, one register per offset
// Notes:   Definitions only
`ifndef CANCX_MAP_SVH
`define CANCX_MAP_SVH
// ==========================================================================
// Register offsets
`define CANCX_A_MODE      8'h00
`define CANCX_A_CMD       8'h01
`define CANCX_A_IE        8'h04
`define CANCX_A_TXREQ     8'h05
`define CANCX_A_BT0       8'h09
`define CANCX_A_BT1       8'h0a
`define CANCX_A_RXBUF     8'h10
`define CANCX_A_RXEND     8'h1d
`define CANCX_A_FILT      8'h40
`define CANCX_A_MASK      8'h50
`define CANCX_A_ACCEND    8'h6f
`define CANCX_A_FEN_L     8'h70
`define CANCX_A_FEN_H     8'h71
`define CANCX_A_FIE_L     8'h72
`define CANCX_A_FIE_H     8'h73
`define CANCX_A_ST_L      8'h74
`define CANCX_A_ST_H      8'h75
`define CANCX_A_CLKSRC    8'h78
`define CANCX_A_RXCNT     8'h7a
`define CANCX_A_LOCK      8'h7f
`define CANCX_A_TXINFO    8'h81
`define CANCX_A_TXLAST    4'hd
// ==========================================================================
// Values
`define CANCX_MODE_RST    8'h01
`define CANCX_MODE_RUN    8'hc8
`define CANCX_UNLOCK_KEY  8'ha6
`define CANCX_CLK_XTAL    8'h0c
`define CANCX_MASK_ALL    8'hff
`define CANCX_STD_MAX     32'h0000_07ff
`define CANCX_EXT_MAX     32'h1fff_ffff
`define CANCX_DLC_MAX     4'h8
`define CANCX_RX_BYTES    14
`define CANCX_INIT_STEPS  5'h0e
// ==========================================================================
// Field positions
`define CANCX_MODE_RSTB   0
`define CANCX_MODE_LOM    1
`define CANCX_MODE_NSPD   6
`define CANCX_MODE_XCVR   7
`define CANCX_FI_EXT      7
`define CANCX_STH_OVR     0
`define CANCX_STH_TXOK    1
`define CANCX_STH_ARBL    2
`define CANCX_STH_TXREJ   3
`endif

//--- rtl/cancx_pkg.sv
// Purpose: Types shared by both ends of the CAN register port
// Assumes: Offsets and values live in cancx_map.svh
// Notes:   State of the controller and of the host is one packed struct each
package cancx_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_ARB, TX_SEND} cancx_tx_st_t;
  typedef enum logic [2:0] {H_IDLE, H_INIT, H_RXRD, H_REL, H_CNT, H_STAT, H_TXLD, H_TXGO}
    cancx_host_st_t;
  typedef struct packed {
    logic [7:0]            mode;
    logic [7:0]            ie;
    logic [7:0]            txreq;
    logic [1:0][7:0]       bt;
    logic [47:0][7:0]      acc;
    logic [15:0]           fen;
    logic [15:0]           fie;
    logic [7:0]            st_l;
    logic [7:0]            st_h;
    logic [7:0]            clksrc;
    logic                  unlocked;
    logic [7:0][12:0][7:0] txb;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic                  irq_n;
    cancx_tx_st_t          tx_st;
    logic [2:0]            tx_grp;
    logic                  tx_valid;
    logic [7:0]            tx_info;
    logic [31:0]           tx_id;
    logic [63:0]           tx_data;
  } cancx_dev_t;
  typedef struct packed {
    cancx_host_st_t        st;
    logic [4:0]            idx;
    logic                  waitr;
    logic                  wr;
    logic                  rd;
    logic [7:0]            addr;
    logic [7:0]            wdata;
    logic [12:0][7:0]      txb;
    logic                  init_done;
    logic [7:0]            rx_byte;
    logic [3:0]            rx_idx;
    logic                  rx_valid;
    logic                  rx_last;
    logic [15:0]           status;
  } cancx_host_t;
endpackage

//--- rtl/cancx_rxfifo.sv
// Purpose: Receive frame FIFO with frame count
// Assumes: Push is dropped by the caller when full
// Notes:   Head word is valid whenever count is nonzero
`timescale 1ns/10ps
module cancx_rxfifo #(
  parameter int W     = 112,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  // Write side
  input  wire logic         push_i,
  input  wire logic [W-1:0] wdata_i,
  // Read side
  input  wire logic         pop_i,
  output logic      [W-1:0] head_o,
  output logic      [7:0]   count_o,
  output logic              full_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [7:0]    cnt;
  } cancx_fifo_t;
  cancx_fifo_t      q, d;
  logic [W-1:0]     mem [DEPTH];
  logic             do_push;
  logic             do_pop;

  assign full_o  = (q.cnt == 8'(DEPTH));
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && (q.cnt != 8'h00);
  assign head_o  = mem[q.rp];
  assign count_o = q.cnt;

  always_comb begin
    d = q;
    if (do_push) begin
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (do_pop) begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = 8'(q.cnt + {7'h00, do_push} - {7'h00, do_pop});
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage has no reset; only words below the count are ever read
  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem[q.wp] <= wdata_i;
    end
  end
endmodule // cancx_rxfifo

//--- tb/cancx_props.sv
// Purpose: Checks on the register port between host and controller
// Assumes: One clock, reset active low
// Notes:   Shadows follow the mode and interrupt enable writes
`timescale 1ns/10ps
module cancx_props #(parameter int RX_DEPTH = 8) (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  // Register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       irq_n
);
  logic [7:0] mode_r;
  logic [7:0] ie_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r <= 8'h01;
      ie_r   <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h00) begin
      mode_r <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h04) begin
      ie_r <= reg_wdata;
    end
  end
  // ==========
  // Port timing, read data and interrupt
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
  a_info_format: assert property (reg_rd && reg_addr == 8'h10 |=>
    reg_rdata[6:4] == 3'h0 && reg_rdata[3:0] <= 4'h8) else $error("bad frame info");
  a_count_bound: assert property (reg_rd && reg_addr == 8'h7a |=>
    reg_rdata <= RX_DEPTH) else $error("frame count too big");
  a_irq_masked: assert property (!ie_r[0] && !$past(ie_r[0]) |-> irq_n)
    else $error("interrupt while masked");
  a_irq_resetmode: assert property (mode_r[0] && $past(mode_r[0]) |-> irq_n)
    else $error("interrupt in reset mode");
  a_irq_release: assert property (reg_rd && reg_addr == 8'h74 |=> irq_n)
    else $error("interrupt kept after status read");
  cover property ($fell(irq_n));
  cover property (reg_rd && reg_addr == 8'h7a ##1 reg_rdata == 8'h01);
  cover property (reg_wr && reg_addr == 8'h05);
endmodule // cancx_props

//--- tb/cancx_test.sv
// Purpose: Self-checking bench for host and controller ends
// Assumes: 250 MHz clock, stimulus on the falling edge
// Notes:   Receive bytes and offered frames are checked from queues
`timescale 1ns/10ps
module cancx_test;
  logic sys_clk_i = 1'h0, nrst_i = 1'h0, init_s = 1'h0, txs = 1'h0, rxv = 1'h0, done = 1'h0;
  logic rv = 1'h0;
  logic [31:0] seed = 32'h245d, r, tid = 32'h0;
  logic [103:0] b, txq[$];
  logic [63:0] td = 64'h0;
  logic [7:0] ti = 8'h0, rxq[$];
  logic [39:0] cases[4] = '{40'h08000007ff, 40'h881fffffff, 40'h0800000800, 40'h0900000000};
  int fail_count, check_count, lasts;
  logic tv_prev;
  wire idone, busy, rval, rlast, tx_valid, xcvr, nspd, lom;
  wire [7:0] rbyte, tx_info, clk_src;
  wire [3:0] ridx;
  wire [15:0] stat, bt;
  wire [31:0] tx_id;
  wire [63:0] tx_data;
  cancx_if cancx_if_i ();
  cancx_dev cancx_dev_i (.sys_clk_i, .nrst_i, .bus(cancx_if_i), .can_rx_valid_i(rxv),
    .can_rx_ext_i(b[103]), .can_rx_id_i(b[92:64]), .can_rx_dlc_i(b[99:96]),
    .can_rx_data_i(b[63:0]), .can_tx_valid_o(tx_valid), .can_tx_info_o(tx_info),
    .can_tx_id_o(tx_id), .can_tx_data_o(tx_data), .can_rival_valid_i(rv),
    .can_rival_ext_i(1'h0), .can_rival_id_i(29'h0), .can_tx_done_i(done), .xcvr_en_o(xcvr),
    .normal_speed_o(nspd), .listen_only_o(lom), .clk_src_o(clk_src), .bit_timing_o(bt));
  cancx_host cancx_host_i (.sys_clk_i, .nrst_i, .bus(cancx_if_i), .init_start_i(init_s),
    .tx_start_i(txs), .tx_info_i(ti), .tx_id_i(tid), .tx_data_i(td), .init_done_o(idone),
    .busy_o(busy), .rx_byte_o(rbyte), .rx_idx_o(ridx), .rx_valid_o(rval), .rx_last_o(rlast),
    .status_o(stat));
  cancx_props cancx_props_i (.sys_clk_i, .nrst_i, .reg_wr(cancx_if_i.reg_wr),
    .reg_rd(cancx_if_i.reg_rd), .reg_addr(cancx_if_i.reg_addr),
    .reg_wdata(cancx_if_i.reg_wdata), .reg_rdata(cancx_if_i.reg_rdata),
    .reg_rvalid(cancx_if_i.reg_rvalid), .irq_n(cancx_if_i.irq_n));
  always #2 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string n, input logic [103:0] seen, input logic [103:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Two frames in a row may be sent; the last one is lowered by the caller
  task automatic frame();
    r = rnd();
    b = {r[31], 3'h0, 4'(r % 9), 3'h0, r[28:0], rnd(), rnd()};
    for (int i = 12; i >= 0; i--) rxq.push_back(b[8*i+:8]);
    rxq.push_back(8'h00);
    rxv = 1'h1;
    @(negedge sys_clk_i);
  endtask
  task automatic drain(input int n);
    rxv = 1'h0;
    repeat (2000) begin
      @(negedge sys_clk_i);
      if (lasts >= n && busy === 1'h0) break;
    end
    check("status", stat[7:0], 8'h01);
    check("frames", lasts, n);
    $display("drained %0d frames", n);
  endtask
  // ==========
  // Result watcher
  always @(negedge sys_clk_i) begin
    if (rval === 1'h1) check("rx byte", rbyte, rxq.pop_front());
    if (rlast === 1'h1) lasts++;
    if (tx_valid === 1'h1 && tv_prev !== 1'h1) check("tx", {tx_info, tx_id, tx_data}, txq.pop_front());
    tv_prev = tx_valid;
  end
  initial begin
    #200000 fail_count++;
    results();
  end
  initial begin
    repeat (4) @(negedge sys_clk_i);
    nrst_i = 1'h1;
    init_s = 1'h1;
    @(negedge sys_clk_i) init_s = 1'h0;
    repeat (100) begin
      @(negedge sys_clk_i);
      if (idone === 1'h1) break;
    end
    // Done rises with the last mode write; let that write land first
    @(negedge sys_clk_i);
    check("config", {clk_src, bt, xcvr, nspd, lom}, {8'h0c, 16'h3a40, 3'h6});
    $display("init test done");
    frame();
    frame();
    drain(2);
    frame();
    drain(3);
    for (int i = 0; i < 4; i++) begin
      {ti, tid} = cases[i];
      td = {rnd(), rnd()};
      if (i < 2) txq.push_back({ti, tid, td});
      if (i == 0) txq.push_back({ti, tid, td});
      rv = (i == 0);
      txs = 1'h1;
      @(negedge sys_clk_i) txs = 1'h0;
      repeat (60) begin
        @(negedge sys_clk_i);
        if (tx_valid === 1'h1) break;
      end
      check("tx offered", tx_valid, i < 2);
      // Case 0 loses to the rival once, then is offered again
      @(negedge sys_clk_i) rv = 1'h0;
      check("tx arb", tx_valid, i == 1);
      if (i == 0) repeat (3) @(negedge sys_clk_i);
      done = 1'h1;
      @(negedge sys_clk_i) done = 1'h0;
      repeat (2) @(negedge sys_clk_i);
      check("tx released", tx_valid, 1'h0);
    end
    $display("transmit test done");
    results();
  end
endmodule // cancx_test
